// >>> hw/dcio_top.sv
`timescale 1ns/1ps
`include "dcio_cfg.svh"
// How it works
// - with check on, a masked input bit updates only after two equal consecutive receptions
// - check gives one to two cycle times from line change to input update
// - cycle is 2.4ms for 64 points and 3.6ms for 128 points
// - cycle is 6.0ms for 256 points and 10.7ms for 512 points
// - with check off, line delay lies between zero and one cycle time
// - input path adds 1.5ms bridge processing before device area changes
// - output path sends the held frame on the cycle tick with no bridge processing delay
module dcio_top #(
	parameter int NIN = 256,
	parameter int CYC64 = `DCIO_CYC64_US * `DCIO_CLK_MHZ,
	parameter int CYC128 = `DCIO_CYC128_US * `DCIO_CLK_MHZ,
	parameter int CYC256 = `DCIO_CYC256_US * `DCIO_CLK_MHZ,
	parameter int CYC512 = `DCIO_CYC512_US * `DCIO_CLK_MHZ,
	parameter int PROC = `DCIO_PROC_US * `DCIO_CLK_MHZ
) (
	// clock and reset
	input wire logic CLK,
	input wire logic RST,
	// configuration, sampled at reset release
	input wire logic DCHK_EN,
	input wire dcio_pkg::dcio_pts_t PTS_SEL,
	input wire logic [NIN-1:0] CHK_MASK,
	// line side input frame
	input wire logic [NIN-1:0] LINE_IN,
	input wire logic LINE_VALID,
	// line side output frame
	input wire logic [NIN-1:0] HOST_OUT,
	output logic [NIN-1:0] LINE_OUT,
	output logic LINE_OUT_STB,
	// device side input area
	output logic [NIN-1:0] IN_AREA,
	output logic IN_STB,
	// cycle timing
	output logic CYC_TICK
);
	// elaboration check on the frame width
	if (NIN < 1 || NIN > 256) begin : g_nin_chk
		$error("dcio_top: NIN out of range");
	end
	dcio_tick_if tk();
	logic init_q, init_d;
	logic en_q, en_d;
	dcio_pkg::dcio_pts_t pts_q, pts_d;
	logic [NIN-1:0] msk_q, msk_d;
	logic [NIN-1:0] prev_q, prev_d, filt_q, filt_d, stage_q, stage_d;
	logic [NIN-1:0] area_q, area_d, lo_q, lo_d, hold_q, hold_d;
	logic stb_q, stb_d, lstb_q, lstb_d, ovalid_q, ovalid_d;
	dcio_pkg::dcio_st_e st_q, st_d;
	dcio_timer #(.CYC64(CYC64), .CYC128(CYC128), .CYC256(CYC256), .CYC512(CYC512),
		.PROC(PROC)) u_tmr (.clk(CLK), .rst(RST), .tk(tk));
	assign tk.pts = pts_q;
	assign tk.proc_start = LINE_VALID || (tk.cyc_tick && ovalid_q);
	assign CYC_TICK = tk.cyc_tick;
	assign IN_AREA = area_q;
	assign IN_STB = stb_q;
	assign LINE_OUT = lo_q;
	assign LINE_OUT_STB = lstb_q;
	// double check of one frame against the previous one
	function automatic logic [NIN-1:0] dchk(input logic [NIN-1:0] cur, input logic [NIN-1:0] prv,
		input logic [NIN-1:0] held, input logic [NIN-1:0] m, input logic en);
		logic [NIN-1:0] eq;
		eq = ~(cur ^ prv);
		if (!en)
			dchk = cur;
		else
			dchk = ((cur & eq) | (held & ~eq)) & m | cur & ~m;
	endfunction
	//////////////////////////////////////////////////////////////////
	// configuration latch, settings take effect only from reset
	always_comb begin
		init_d = 1'b1;
		en_d = en_q;
		pts_d = pts_q;
		msk_d = msk_q;
		if (!init_q) begin
			en_d = DCHK_EN;
			pts_d = PTS_SEL;
			msk_d = CHK_MASK;
		end
	end
	//////////////////////////////////////////////////////////////////
	// input filter and processing delay to the area
	always_comb begin
		prev_d = prev_q;
		filt_d = filt_q;
		stage_d = stage_q;
		area_d = area_q;
		st_d = st_q;
		stb_d = 1'b0;
		if (LINE_VALID) begin
			filt_d = dchk(LINE_IN, prev_q, filt_q, msk_q, en_q);
			prev_d = LINE_IN;
			stage_d = filt_d;
			st_d = dcio_pkg::DCIO_WAIT;
		end else begin
			case (st_q)
				dcio_pkg::DCIO_IDLE: st_d = dcio_pkg::DCIO_IDLE;
				dcio_pkg::DCIO_WAIT: begin
					if (tk.proc_tick) begin
						area_d = stage_q;
						stb_d = 1'b1;
						st_d = dcio_pkg::DCIO_IDLE;
					end
				end
				default: st_d = dcio_pkg::DCIO_IDLE;
			endcase
		end
	end
	//////////////////////////////////////////////////////////////////
	// output path, held and sent on each cycle tick
	always_comb begin
		hold_d = HOST_OUT;
		ovalid_d = 1'b1;
		lo_d = lo_q;
		lstb_d = 1'b0;
		if (tk.cyc_tick && ovalid_q) begin
			lo_d = hold_q;
			lstb_d = 1'b1;
		end
	end
	//////////////////////////////////////////////////////////////////
	// registers
	always_ff @(posedge CLK) begin
		if (RST) begin
			init_q <= 1'b0;
			en_q <= 1'b0;
			pts_q <= `DCIO_PTS64;
			msk_q <= '0;
			prev_q <= '0;
			filt_q <= '0;
			stage_q <= '0;
			area_q <= '0;
			lo_q <= '0;
			hold_q <= '0;
			stb_q <= 1'b0;
			lstb_q <= 1'b0;
			ovalid_q <= 1'b0;
			st_q <= dcio_pkg::DCIO_IDLE;
		end else begin
			init_q <= init_d;
			en_q <= en_d;
			pts_q <= pts_d;
			msk_q <= msk_d;
			prev_q <= prev_d;
			filt_q <= filt_d;
			stage_q <= stage_d;
			area_q <= area_d;
			lo_q <= lo_d;
			hold_q <= hold_d;
			stb_q <= stb_d;
			lstb_q <= lstb_d;
			ovalid_q <= ovalid_d;
			st_q <= st_d;
		end
	end
endmodule // dcio_top

// >>> hw/dcio_cfg.svh
`ifndef DCIO_CFG_SVH
`define DCIO_CFG_SVH
// transmission cycle times in microseconds, per point count
`define DCIO_CYC64_US 2400
`define DCIO_CYC128_US 3600
`define DCIO_CYC256_US 6000
`define DCIO_CYC512_US 10700
// bridge processing time in microseconds
`define DCIO_PROC_US 1500
// clock rate in MHz
`define DCIO_CLK_MHZ 100
// point count select codes
`define DCIO_PTS64 2'h0
`define DCIO_PTS128 2'h1
`define DCIO_PTS256 2'h2
`define DCIO_PTS512 2'h3
`endif

// >>> hw/dcio_pkg.sv
package dcio_pkg;
	typedef logic [1:0] dcio_pts_t;
	typedef enum logic [1:0] {DCIO_IDLE, DCIO_WAIT, DCIO_DONE} dcio_st_e;
endpackage

// >>> hw/dcio_tick_if.sv
`timescale 1ns/1ps
// cycle timing signals between the top and the timer
interface dcio_tick_if;
	logic [1:0] pts;
	logic cyc_tick;
	logic proc_tick;
	logic proc_start;
	modport tmr (input pts, input proc_start, output cyc_tick, output proc_tick);
	modport top (output pts, output proc_start, input cyc_tick, input proc_tick);
endinterface

// >>> hw/dcio_timer.sv
`timescale 1ns/1ps
`include "dcio_cfg.svh"
// transmission cycle tick generator and processing delay timer
module dcio_timer #(
	parameter int CYC64 = `DCIO_CYC64_US * `DCIO_CLK_MHZ,
	parameter int CYC128 = `DCIO_CYC128_US * `DCIO_CLK_MHZ,
	parameter int CYC256 = `DCIO_CYC256_US * `DCIO_CLK_MHZ,
	parameter int CYC512 = `DCIO_CYC512_US * `DCIO_CLK_MHZ,
	parameter int PROC = `DCIO_PROC_US * `DCIO_CLK_MHZ
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// timing
	dcio_tick_if.tmr tk
);
	// elaboration check: counts must fit the 24 bit counters
	if (CYC64 < 2 || CYC128 < 2 || CYC256 < 2 || CYC512 < 2 || PROC < 1 ||
		CYC512 > 16777215 || PROC > 16777215) begin : g_cnt_chk
		$error("dcio_timer: counts out of range");
	end
	logic [23:0] cnt_q, cnt_d, len;
	logic [23:0] pc_q, pc_d;
	logic pb_q, pb_d;
	// cycle length per point count
	always_comb begin
		case (tk.pts)
			`DCIO_PTS64: len = 24'(CYC64);
			`DCIO_PTS128: len = 24'(CYC128);
			`DCIO_PTS256: len = 24'(CYC256);
			default: len = 24'(CYC512);
		endcase
	end
	// cycle counter next state
	always_comb begin
		cnt_d = (cnt_q >= len - 24'h000001) ? 24'h000000 : cnt_q + 24'h000001;
		tk.cyc_tick = (cnt_q >= len - 24'h000001);
	end
	// processing delay next state
	always_comb begin
		pb_d = pb_q;
		pc_d = pc_q;
		tk.proc_tick = 1'b0;
		if (tk.proc_start) begin
			pb_d = 1'b1;
			pc_d = 24'h000000;
		end else if (pb_q) begin
			if (pc_q >= 24'(PROC) - 24'h000001) begin
				pb_d = 1'b0;
				tk.proc_tick = 1'b1;
			end else begin
				pc_d = pc_q + 24'h000001;
			end
		end
	end
	// registers
	always_ff @(posedge clk) begin
		if (rst) begin
			cnt_q <= 24'h000000;
			pc_q <= 24'h000000;
			pb_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			pc_q <= pc_d;
			pb_q <= pb_d;
		end
	end
endmodule // dcio_timer

// >>> tb/dcio_chk_props.sv
`timescale 1ns/1ps
// port checker for the filter top
module dcio_chk #(parameter int NIN = 4, CYC64 = 20, CYC128 = 30, CYC256 = 40, CYC512 = 50,
	PROC = 5) (
	// clock and reset
	input wire logic CLK,
	input wire logic RST,
	// settings
	input wire logic DCHK_EN,
	input wire dcio_pkg::dcio_pts_t PTS_SEL,
	input wire logic [NIN-1:0] CHK_MASK,
	// line and area
	input wire logic [NIN-1:0] LINE_IN,
	input wire logic LINE_VALID,
	input wire logic [NIN-1:0] LINE_OUT,
	input wire logic LINE_OUT_STB,
	input wire logic [NIN-1:0] IN_AREA,
	input wire logic IN_STB,
	input wire logic CYC_TICK
);
	logic [NIN-1:0] f1_q, f2_q;
	logic [1:0] nf_q;
	logic st_q;
	int dq_q, cq_q, len;
	wire [NIN-1:0] m = DCHK_EN ? CHK_MASK : '0;
	assign len = PTS_SEL == 2'h0 ? CYC64 : PTS_SEL == 2'h1 ? CYC128 : PTS_SEL == 2'h2 ? CYC256 : CYC512;
	// last two frames and cycles since frame and tick
	always_ff @(posedge CLK) begin
		if (RST) begin
			nf_q <= 2'h0;
			st_q <= 1'b0;
		end else begin
			if (LINE_VALID) begin
				f1_q <= LINE_IN;
				f2_q <= f1_q;
				nf_q <= {nf_q[0], 1'b1};
			end
			dq_q <= LINE_VALID ? 0 : dq_q + 1;
			cq_q <= CYC_TICK ? 0 : cq_q + 1;
			st_q <= st_q | CYC_TICK;
		end
	end
	default clocking @(posedge CLK); endclocking
	default disable iff (RST);
	a_stb_delay: assert property (IN_STB |-> dq_q == PROC)
		else $error("input strobe delay wrong");
	a_stb_pulse: assert property (IN_STB |=> !IN_STB)
		else $error("input strobe too long");
	a_area_hold: assert property (!IN_STB |-> $stable(IN_AREA))
		else $error("area moved without strobe");
	a_chk_hold: assert property (IN_STB && nf_q[1] |-> (m & (f1_q ^ f2_q) & (IN_AREA ^ $past(IN_AREA))) == '0)
		else $error("checked bit moved on one frame");
	a_chk_take: assert property (IN_STB && nf_q[1] |-> (m & ~(f1_q ^ f2_q) & (IN_AREA ^ f1_q)) == '0)
		else $error("checked bit not taken after two frames");
	a_nochk_follow: assert property (IN_STB |-> (~m & (IN_AREA ^ f1_q)) == '0)
		else $error("unchecked bit not following frame");
	a_tick_period: assert property (CYC_TICK && st_q |-> cq_q == len - 1)
		else $error("cycle tick period wrong");
	a_out_stb: assert property (LINE_OUT_STB |-> $past(CYC_TICK) || $past(CYC_TICK, 2))
		else $error("output strobe off tick");
	a_out_change: assert property ($changed(LINE_OUT) |-> ##[0:1] LINE_OUT_STB)
		else $error("output frame changed without strobe");
endmodule // dcio_chk
bind dcio_top dcio_chk #(.NIN(NIN), .CYC64(CYC64), .CYC128(CYC128), .CYC256(CYC256),
	.CYC512(CYC512), .PROC(PROC)) u_chk (.*);

// >>> tb/dcio_slave.sv
`timescale 1ns/1ps
// slave model: frame after each tick, double-checked output
module dcio_slave #(parameter int N = 4) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// line
	input wire logic tick,
	input wire logic [N-1:0] src,
	input wire logic [N-1:0] lout,
	input wire logic lstb,
	output logic [N-1:0] lin,
	output logic lval,
	output logic [N-1:0] dout
);
	logic [N-1:0] lp_q;
	// idle line toggles so stale data never looks valid
	always_ff @(posedge clk) begin
		lval <= tick & !rst;
		lin <= tick ? src : ~lin;
		if (rst)
			dout <= '0;
		else if (lstb && lout == lp_q)
			dout <= lout;
		if (lstb)
			lp_q <= lout;
	end
endmodule // dcio_slave

// >>> tb/testbench.sv
`timescale 1ns/1ps
// self-checking bench for the double-check filter
module testbench;
	localparam int CY [4] = '{20, 30, 40, 50};
	logic CLK = 1'b0;
	logic RST = 1'b1;
	logic DCHK_EN = 1'b1;
	logic [1:0] PTS_SEL = 2'h0;
	logic [3:0] CHK_MASK = 4'h3, src = 4'h0, HOST_OUT = 4'h0;
	logic [3:0] LINE_IN, LINE_OUT, IN_AREA, dout;
	logic LINE_VALID, LINE_OUT_STB, IN_STB, CYC_TICK;
	int mismatches = 0, n_tests = 0, n;
	// src, host, expected area, expected output
	logic [15:0] rows [4] = '{16'h5C5C, 16'hA3A3, 16'hF0F0, 16'h0F0F};
	always #5 CLK = ~CLK;
	dcio_top #(.NIN(4), .CYC64(CY[0]), .CYC128(CY[1]), .CYC256(CY[2]), .CYC512(CY[3]),
		.PROC(5)) dut (.*);
	dcio_slave #(.N(4)) slave (.clk(CLK), .rst(RST), .tick(CYC_TICK), .src(src),
		.lout(LINE_OUT), .lstb(LINE_OUT_STB), .lin(LINE_IN), .lval(LINE_VALID), .dout(dout));
	task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
		n_tests++;
		if (e !== g) begin
			mismatches++;
			$display("CHECK FAILED %s exp %0h got %0h", nm, e, g);
		end
	endtask
	task automatic print_verdict();
		$display("tests %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// bounded wait for k cycle ticks
	task automatic tick(int k);
		repeat (k) begin
			for (n = 0; n < 200; n++) begin
				@(posedge CLK);
				#1;
				if (CYC_TICK) break;
			end
			if (n == 200) begin
				mismatches++;
				print_verdict();
			end
		end
	endtask
	task automatic rst(logic en, logic [1:0] p);
		RST = 1'b1;
		DCHK_EN = en;
		PTS_SEL = p;
		repeat (12) @(posedge CLK);
		#1 RST = 1'b0;
	endtask
	// one frame of v only, then look at the area
	task automatic pulse(logic [3:0] v, logic [3:0] e);
		src = v;
		tick(1);
		@(posedge CLK);
		#1 src = 4'h0;
		repeat (8) @(posedge CLK);
		#1 chk("pulse", 32'(e), 32'(IN_AREA));
	endtask
	initial begin
		rst(1'b1, 2'h0);
		foreach (rows[i]) begin
			src = rows[i][15:12];
			HOST_OUT = rows[i][11:8];
			tick(3);
			repeat (7) @(posedge CLK);
			#1 chk("area", 32'(rows[i][7:4]), 32'(IN_AREA));
			chk("line out", 32'(rows[i][3:0]), 32'(LINE_OUT));
			chk("slave out", 32'(rows[i][3:0]), 32'(dout));
		end
		pulse(4'h5, 4'h4);
		for (int p = 0; p < 4; p++) begin
			rst(1'b0, 2'(p));
			tick(1);
			tick(1);
			chk("period", CY[p], n + 1);
		end
		pulse(4'h1, 4'h1);
		print_verdict();
	end
endmodule // testbench
